// [logic/vmcr_params.svh]
// constants for the module control register bank: offsets, field positions, reset values
// assumes inclusion by bare name from the register bank and its readout engine
`ifndef VMCR_PARAMS_SVH
`define VMCR_PARAMS_SVH

// register offsets from the module base address
`define VMCR_OFF_SLOT 16'h1002
`define VMCR_OFF_BCAST 16'h1004
`define VMCR_OFF_SET1 16'h1006
`define VMCR_OFF_CLR1 16'h1008
`define VMCR_OFF_ILEV 16'h100A
`define VMCR_OFF_IVEC 16'h100C
`define VMCR_OFF_STAT1 16'h100E
`define VMCR_OFF_CTRL1 16'h1010
`define VMCR_OFF_ADHI 16'h1012

// set/clear control register fields
`define VMCR_B_BERR 3
`define VMCR_B_SELADDR 4
`define VMCR_B_SOFTRST 7

// general control register fields
`define VMCR_B_STOPFIRST 2
`define VMCR_B_PANELSCOPE 4
`define VMCR_B_BERREN 5
`define VMCR_B_ALIGN 6

// status register fields
`define VMCR_B_DAVAIL 0
`define VMCR_B_CHAINDAV 1
`define VMCR_B_BUSY 2
`define VMCR_B_CHAINBUSY 3
`define VMCR_B_SLOTMISS 4
`define VMCR_B_EVTHR 8

// reset values
`define VMCR_RST_SLOT 5'h1F
`define VMCR_RST_BCAST 8'hAA
`define VMCR_RST_ILEV 3'h0
`define VMCR_RST_IVEC 8'h00
`define VMCR_RST_ADHI 8'h00

// readout word typing
`define VMCR_NOT_VALID_WORD 32'h0600_0000

`endif

// [logic/vmcr_pkg.sv]
// types shared by the module control register bank and its readout engine
// constants live in vmcr_params.svh
package vmcr_pkg;

  typedef logic [15:0] vmcr_word_t;
  typedef logic [31:0] vmcr_data_t;

  // readout engine states
  typedef enum logic [2:0] {
    RO_IDLE = 3'b001,
    RO_PAD = 3'b010,
    RO_DONE = 3'b100
  } vmcr_ro_e;

  // decoded register selects
  typedef enum logic [3:0] {
    SEL_NONE, SEL_SLOT, SEL_BCAST, SEL_SET1, SEL_CLR1,
    SEL_ILEV, SEL_IVEC, SEL_STAT1, SEL_CTRL1, SEL_ADHI
  } vmcr_sel_e;

endpackage

// [logic/vmcr_sync.sv]
// two-stage synchroniser for pins arriving from outside the mclk domain
// assumes the bits are independent levels; multi-bit words must be quasi-static
`timescale 1ns/10ps
module vmcr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // level in and out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else if (ce) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// [logic/vmcr_readout.sv]
// block-transfer readout word sequencer: stop-at-first-event, padding, bus error end
// assumes the output buffer shows its head word with valid/eob/last flags on mclk
`timescale 1ns/10ps
module vmcr_readout (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic soft_rst,
  // mode bits
  input wire logic stop_first,
  input wire logic berr_en,
  input wire logic pad_en,
  // transfer strobes
  input wire logic blt_rd,
  input wire logic blt_end,
  // output buffer head
  input wire vmcr_pkg::vmcr_data_t buf_word,
  input wire logic buf_valid,
  input wire logic buf_eob,
  input wire logic buf_last,
  output logic buf_pop,
  // answer
  output vmcr_pkg::vmcr_data_t blt_data,
  output logic blt_ack,
  output logic blt_berr
);
  import vmcr_pkg::*;
`include "vmcr_params.svh"

  vmcr_ro_e state_q;
  logic odd_q;
  logic term_pend_q;
  logic take, term, pad, end_berr;

  always_comb begin
    take = blt_rd && (state_q == RO_IDLE) && buf_valid;
    term = take && ((stop_first && buf_eob) || buf_last);
    // odd word count at end of block: one dummy word, unless a bus error ends it here
    pad = take && buf_eob && pad_en && !odd_q && !(term && berr_en);
    // terminal word, or any read that takes no word outside the pad state, ends with a bus error
    end_berr = berr_en && (term || (blt_rd && !take && state_q != RO_PAD));
  end

  assign buf_pop = ce && take;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RO_IDLE;
      term_pend_q <= 1'b0;
    end else if (ce) begin
      if (soft_rst || blt_end) begin
        state_q <= RO_IDLE;
        term_pend_q <= 1'b0;
      end else begin
        case (state_q)
          RO_IDLE: begin
            if (pad) begin
              state_q <= RO_PAD;
              term_pend_q <= term;
            end else if (term) begin
              state_q <= RO_DONE;
            end
          end
          RO_PAD: begin
            if (blt_rd) begin
              state_q <= term_pend_q ? RO_DONE : RO_IDLE;
              term_pend_q <= 1'b0;
            end
          end
          RO_DONE: state_q <= RO_DONE;
          default: state_q <= RO_IDLE;
        endcase
      end
    end
  end

  // word parity within the current event, header counted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      odd_q <= 1'b0;
    end else if (ce) begin
      if (soft_rst || blt_end) begin
        odd_q <= 1'b0;
      end else if (take) begin
        odd_q <= buf_eob ? 1'b0 : ~odd_q;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blt_data <= '0;
      blt_ack <= 1'b0;
      blt_berr <= 1'b0;
    end else if (ce) begin
      blt_ack <= blt_rd && !end_berr;
      blt_berr <= end_berr;
      if (blt_rd) begin
        blt_data <= take ? buf_word : `VMCR_NOT_VALID_WORD;
      end
    end
  end
endmodule

// [logic/vmcr_top.sv]
// module control and status register bank of a multichannel charge digitiser
// assumes a one-cycle register strobe port on mclk behind the bus interface logic,
// pins from the backplane and front panel arriving asynchronously
`timescale 1ns/10ps
module vmcr_top #(
  parameter bit HAS_AUX = 1'b1,
  parameter int EVCNT_W = 5
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire vmcr_pkg::vmcr_word_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire vmcr_pkg::vmcr_word_t reg_wdata,
  output vmcr_pkg::vmcr_word_t reg_rdata,
  output logic reg_ack,
  // interrupter
  input wire logic iack,
  output logic [7:0] iack_data,
  output logic iack_ack,
  output logic [2:0] irq_level,
  output logic irq_req,
  // asynchronous pins
  input wire logic [4:0] backplane_aux_connector,
  input wire logic chain_ready_line,
  input wire logic chain_busy_line,
  input wire logic panel_reset,
  input wire logic [7:0] rotary_addr_high,
  // status from the acquisition core
  input wire logic event_in_buffer,
  input wire logic conv_active,
  input wire logic buffer_full,
  input wire logic mem_test,
  input wire logic [EVCNT_W-1:0] event_count,
  input wire logic [EVCNT_W-1:0] event_trigger,
  // base address selection
  output logic base_from_decoder,
  output logic [7:0] base_addr_high,
  output logic [7:0] broadcast_chain_addr,
  output logic [4:0] slot_position_code,
  // block transfer readout
  input wire logic blt_rd,
  input wire logic blt_end,
  input wire logic blt_wide,
  input wire vmcr_pkg::vmcr_data_t buf_word,
  input wire logic buf_valid,
  input wire logic buf_eob,
  input wire logic buf_last,
  output logic buf_pop,
  output vmcr_pkg::vmcr_data_t blt_data,
  output logic blt_ack,
  output logic blt_berr,
  // resets toward the rest of the module
  output logic module_reset,
  output logic data_reset
);
  import vmcr_pkg::*;
`include "vmcr_params.svh"

  function automatic vmcr_sel_e decode(input vmcr_word_t a);
    case (a)
      `VMCR_OFF_SLOT: decode = SEL_SLOT;
      `VMCR_OFF_BCAST: decode = SEL_BCAST;
      `VMCR_OFF_SET1: decode = SEL_SET1;
      `VMCR_OFF_CLR1: decode = SEL_CLR1;
      `VMCR_OFF_ILEV: decode = SEL_ILEV;
      `VMCR_OFF_IVEC: decode = SEL_IVEC;
      `VMCR_OFF_STAT1: decode = SEL_STAT1;
      `VMCR_OFF_CTRL1: decode = SEL_CTRL1;
      `VMCR_OFF_ADHI: decode = SEL_ADHI;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // reset release through two flops
  logic rst_meta_q, rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // pin synchronisers
  logic [4:0] slot_pins;
  logic [7:0] rotary_s;
  logic chain_rdy_s, chain_busy_s, panel_s;

  vmcr_sync #(.W(5)) u_sync_slot (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .din(backplane_aux_connector),
    .dout(slot_pins)
  );

  vmcr_sync #(.W(11)) u_sync_misc (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .din({rotary_addr_high, chain_ready_line, chain_busy_line, panel_reset}),
    .dout({rotary_s, chain_rdy_s, chain_busy_s, panel_s})
  );

  // register state
  logic [4:0] slot_q, slot_pend_q;
  logic slot_missing_q;
  logic [2:0] boot_q;
  logic [7:0] bcast_q;
  logic bus_error_flag_q, sel_addr_q, soft_hold_q;
  logic stop_first_q, panel_scope_q, berr_en_q, align_q;
  logic [2:0] ilev_q;
  logic [7:0] ivec_q;
  logic [7:0] adhi_q;
  logic panel_d_q, panel_soft_q, data_reset_q;

  // decoded strobes
  vmcr_sel_e sel;
  logic wr, rd;
  logic soft_rst;
  logic busy, ev_thr;
  logic ro_berr;

  assign sel = decode(reg_addr);
  assign wr = ce && reg_wr;
  assign rd = ce && reg_rd;
  assign soft_rst = soft_hold_q || panel_soft_q;
  assign busy = conv_active || buffer_full || mem_test || soft_rst;
  assign ev_thr = (event_trigger != '0) && (ilev_q != 3'h0) && (event_count >= event_trigger);

  // front panel reset: rising edge of the synchronised pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      panel_d_q <= 1'b0;
      panel_soft_q <= 1'b0;
      data_reset_q <= 1'b0;
    end else if (ce) begin
      panel_d_q <= panel_s;
      panel_soft_q <= panel_s && !panel_d_q && panel_scope_q;
      data_reset_q <= panel_s && !panel_d_q && !panel_scope_q;
    end
  end

  // slot code: caught after every reset, never taken straight from pins under async reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q <= 3'b000;
      slot_q <= `VMCR_RST_SLOT;
      slot_pend_q <= `VMCR_RST_SLOT;
      slot_missing_q <= !HAS_AUX;
    end else if (ce) begin
      boot_q <= {boot_q[1:0], 1'b1};
      if (!HAS_AUX && wr && sel == SEL_SLOT) begin
        slot_pend_q <= reg_wdata[4:0];
      end
      // the pin synchroniser is still cleared for two edges after release
      if (boot_q == 3'b011 || soft_rst) begin
        slot_q <= HAS_AUX ? slot_pins : slot_pend_q;
        slot_missing_q <= !HAS_AUX;
      end
    end
  end

  // broadcast/chain address and decoder high byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bcast_q <= `VMCR_RST_BCAST;
      adhi_q <= `VMCR_RST_ADHI;
    end else if (ce) begin
      if (wr && sel == SEL_BCAST) begin
        bcast_q <= reg_wdata[7:0];
      end
      if (wr && sel == SEL_ADHI) begin
        adhi_q <= reg_wdata[7:0];
      end
    end
  end

  // set/clear control pair; soft reset clears only the bus-error flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_error_flag_q <= 1'b0;
      sel_addr_q <= 1'b0;
      soft_hold_q <= 1'b0;
    end else if (ce) begin
      // a bus error in the clearing cycle still lands
      if (ro_berr || (wr && sel == SEL_SET1 && reg_wdata[`VMCR_B_BERR])) begin
        bus_error_flag_q <= 1'b1;
      end else if (soft_rst || (wr && sel == SEL_CLR1 && reg_wdata[`VMCR_B_BERR])) begin
        bus_error_flag_q <= 1'b0;
      end
      if (wr && sel == SEL_SET1) begin
        sel_addr_q <= sel_addr_q | reg_wdata[`VMCR_B_SELADDR];
        soft_hold_q <= soft_hold_q | reg_wdata[`VMCR_B_SOFTRST];
      end else if (wr && sel == SEL_CLR1) begin
        sel_addr_q <= sel_addr_q & ~reg_wdata[`VMCR_B_SELADDR];
        soft_hold_q <= soft_hold_q & ~reg_wdata[`VMCR_B_SOFTRST];
      end
    end
  end

  // general control register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stop_first_q <= 1'b0;
      panel_scope_q <= 1'b0;
      berr_en_q <= 1'b0;
      align_q <= 1'b0;
    end else if (ce) begin
      if (soft_rst) begin
        stop_first_q <= 1'b0;
        berr_en_q <= 1'b0;
        align_q <= 1'b0;
      end else if (wr && sel == SEL_CTRL1) begin
        stop_first_q <= reg_wdata[`VMCR_B_STOPFIRST];
        berr_en_q <= reg_wdata[`VMCR_B_BERREN];
        align_q <= reg_wdata[`VMCR_B_ALIGN];
      end
      // scope bit survives soft reset so a panel soft reset cannot disarm itself
      if (wr && sel == SEL_CTRL1) begin
        panel_scope_q <= reg_wdata[`VMCR_B_PANELSCOPE];
      end
    end
  end

  // interrupter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ilev_q <= `VMCR_RST_ILEV;
      ivec_q <= `VMCR_RST_IVEC;
      irq_req <= 1'b0;
      iack_data <= 8'h00;
      iack_ack <= 1'b0;
    end else if (ce) begin
      if (wr && sel == SEL_ILEV) begin
        ilev_q <= reg_wdata[2:0];
      end
      if (wr && sel == SEL_IVEC) begin
        ivec_q <= reg_wdata[7:0];
      end
      irq_req <= (ilev_q != 3'h0) && (event_trigger != '0) && (event_count == event_trigger);
      iack_ack <= iack;
      if (iack) begin
        iack_data <= ivec_q;
      end
    end
  end

  // register read and acknowledge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_ack <= 1'b0;
    end else if (ce) begin
      // aux builds leave a slot write unanswered so the master times out
      reg_ack <= rd || (wr && !(HAS_AUX && sel == SEL_SLOT));
      if (rd) begin
        reg_rdata <= 16'h0000;
        case (sel)
          SEL_SLOT: reg_rdata[4:0] <= slot_q;
          SEL_BCAST: reg_rdata[7:0] <= bcast_q;
          SEL_SET1, SEL_CLR1: begin
            reg_rdata[`VMCR_B_BERR] <= bus_error_flag_q;
            reg_rdata[`VMCR_B_SELADDR] <= sel_addr_q;
            reg_rdata[`VMCR_B_SOFTRST] <= soft_hold_q;
          end
          SEL_ILEV: reg_rdata[2:0] <= ilev_q;
          SEL_IVEC: reg_rdata[7:0] <= ivec_q;
          SEL_STAT1: begin
            reg_rdata[`VMCR_B_DAVAIL] <= event_in_buffer;
            reg_rdata[`VMCR_B_CHAINDAV] <= chain_rdy_s;
            reg_rdata[`VMCR_B_BUSY] <= busy;
            reg_rdata[`VMCR_B_CHAINBUSY] <= chain_busy_s;
            reg_rdata[`VMCR_B_SLOTMISS] <= slot_missing_q;
            reg_rdata[`VMCR_B_EVTHR] <= ev_thr;
          end
          SEL_CTRL1: begin
            reg_rdata[`VMCR_B_STOPFIRST] <= stop_first_q;
            reg_rdata[`VMCR_B_PANELSCOPE] <= panel_scope_q;
            reg_rdata[`VMCR_B_BERREN] <= berr_en_q;
            reg_rdata[`VMCR_B_ALIGN] <= align_q;
          end
          SEL_ADHI: reg_rdata[7:0] <= adhi_q;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  vmcr_readout u_readout (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .soft_rst(soft_rst),
    .stop_first(stop_first_q),
    .berr_en(berr_en_q),
    .pad_en(align_q && blt_wide),
    .blt_rd(blt_rd),
    .blt_end(blt_end),
    .buf_word(buf_word),
    .buf_valid(buf_valid),
    .buf_eob(buf_eob),
    .buf_last(buf_last),
    .buf_pop(buf_pop),
    .blt_data(blt_data),
    .blt_ack(blt_ack),
    .blt_berr(blt_berr)
  );

  assign ro_berr = blt_berr;
  assign irq_level = ilev_q;
  assign base_from_decoder = sel_addr_q;
  assign base_addr_high = sel_addr_q ? adhi_q : rotary_s;
  assign broadcast_chain_addr = bcast_q;
  assign slot_position_code = slot_q;
  assign module_reset = !rst_n || soft_rst;
  assign data_reset = data_reset_q || soft_rst;
endmodule

// [testbench/vmcr_buf_model.sv]
// output buffer head model on the readout side of the register bank
// assumes pops are sampled on the rising mclk edge; words are loaded by the bench
`timescale 1ns/10ps
module vmcr_buf_model (
  // clock
  input wire logic mclk,
  // buffer head
  input wire logic buf_pop,
  output vmcr_pkg::vmcr_data_t buf_word,
  output logic buf_valid,
  output logic buf_eob,
  output logic buf_last
);
  import vmcr_pkg::*;
  logic [32:0] mem [0:15];
  logic [3:0] rd = 4'h0;
  logic [3:0] wr = 4'h0;
  vmcr_data_t last_w = 32'h0000_0000;
  task push(input vmcr_data_t w, input logic end_of_block_word);
    mem[wr] = {end_of_block_word, w};
    wr = wr + 4'h1;
  endtask
  assign buf_valid = rd != wr;
  assign buf_last = (rd + 4'h1) == wr;
  // an empty head shows the inverse of the last word so stale data never matches
  assign buf_word = buf_valid ? mem[rd][31:0] : ~last_w;
  assign buf_eob = buf_valid & mem[rd][32];
  always @(posedge mclk) begin
    if (buf_pop && buf_valid) begin
      last_w <= mem[rd][31:0];
      rd <= rd + 4'h1;
    end
  end
endmodule

// [testbench/vmcr_top_properties.sv]
// port assertions for the module control register bank
// assumes one mclk domain and one-cycle strobes on every request port
`timescale 1ns/10ps
`include "vmcr_params.svh"
module vmcr_top_properties #(
  parameter bit HAS_AUX = 1'b1,
  parameter int EVCNT_W = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire vmcr_pkg::vmcr_word_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire vmcr_pkg::vmcr_word_t reg_wdata,
  input wire logic reg_ack,
  // interrupter
  input wire logic iack,
  input wire logic iack_ack,
  input wire logic [2:0] irq_level,
  input wire logic irq_req,
  input wire logic [EVCNT_W-1:0] event_count,
  input wire logic [EVCNT_W-1:0] event_trigger,
  // readout and reset
  input wire logic blt_rd,
  input wire logic blt_ack,
  input wire logic blt_berr,
  input wire logic module_reset
);
  import vmcr_pkg::*;
  logic strobe, slot_wr, blt_take, trig_hit;
  assign strobe = ce && (reg_rd || reg_wr);
  assign slot_wr = HAS_AUX && reg_wr && reg_addr == `VMCR_OFF_SLOT;
  assign blt_take = ce && blt_rd;
  assign trig_hit = event_count == event_trigger && event_trigger != '0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_strobe_gets_ack: assert property (strobe && !slot_wr |=> reg_ack)
    else $error("register strobe not acknowledged");
  a_slot_write_silent: assert property (ce && slot_wr && !reg_rd |=> !reg_ack)
    else $error("slot write acknowledged");
  a_ack_has_cause: assert property (reg_ack |-> $past(strobe))
    else $error("acknowledge without strobe");
  a_iack_answered: assert property (ce && iack |=> iack_ack)
    else $error("interrupt acknowledge not answered");
  a_iack_has_cause: assert property (iack_ack |-> $past(iack))
    else $error("vector answer without acknowledge");
  a_blt_one_answer: assert property (blt_take |=> blt_ack != blt_berr)
    else $error("block read needs exactly one answer");
  a_blt_has_cause: assert property (blt_ack || blt_berr |-> $past(blt_take))
    else $error("block answer without read");
  // the request is registered from the old level, so look one cycle back
  a_irq_level_zero: assert property (
    irq_level == 3'h0 && $past(irq_level) == 3'h0 |-> !irq_req)
    else $error("interrupt request with level zero");
  a_irq_on_trigger: assert property ($rose(irq_req) |-> $past(trig_hit))
    else $error("interrupt request without trigger match");
  a_soft_reset_holds: assert property (
    ce && reg_wr && reg_addr == `VMCR_OFF_SET1 && reg_wdata[7] |-> ##[1:3] module_reset)
    else $error("soft reset did not take hold");
endmodule
bind vmcr_top vmcr_top_properties #(.HAS_AUX(HAS_AUX), .EVCNT_W(EVCNT_W)) u_props (
  .mclk(mclk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_ack(reg_ack), .iack(iack), .iack_ack(iack_ack),
  .irq_level(irq_level), .irq_req(irq_req), .event_count(event_count),
  .event_trigger(event_trigger), .blt_rd(blt_rd), .blt_ack(blt_ack), .blt_berr(blt_berr),
  .module_reset(module_reset));

// [testbench/tb_vmcr_top.sv]
// bench for the module control register bank with a buffer model on the readout side
// assumes the aux connector build; results are checked from expectation queues
`timescale 1ns/10ps
`include "vmcr_params.svh"
module tb_vmcr_top;
  import vmcr_pkg::*;
  typedef struct {string nm; logic [32:0] ex; bit chk;} vmcr_note_s;
  localparam vmcr_data_t nv_word = 32'h0600_0000;
  logic mclk = 1'b0;
  logic nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, iack = 1'b0, blt_rd = 1'b0, blt_end = 1'b0;
  vmcr_word_t reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  logic [6:0] lv = 7'h00;
  logic [4:0] slot = 5'h00, cnt = 5'h00, trig = 5'h00, slot_position_code;
  logic [7:0] rot = 8'h00, adhi, iack_data, base_addr_high, broadcast_chain_addr;
  logic [2:0] irq_level;
  logic reg_ack, iack_ack, irq_req, base_from_decoder, buf_pop, blt_ack, blt_berr, dr, mr;
  logic module_reset, data_reset, buf_valid, buf_eob, buf_last;
  vmcr_data_t buf_word, blt_data;
  vmcr_note_s rq[$], bq[$], iq[$], n;
  int err_count = 0, tests_run = 0, cycles = 0;
  initial forever #12.5 mclk = ~mclk;
  vmcr_top dut (
    .mclk(mclk), .nrst(nrst), .ce(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .iack(iack), .iack_data(iack_data), .iack_ack(iack_ack), .irq_level(irq_level),
    .irq_req(irq_req), .backplane_aux_connector(slot), .chain_ready_line(lv[1]),
    .chain_busy_line(lv[3]), .panel_reset(lv[6]), .rotary_addr_high(rot),
    .event_in_buffer(lv[0]), .conv_active(lv[2]), .buffer_full(lv[4]), .mem_test(lv[5]),
    .event_count(cnt), .event_trigger(trig), .base_from_decoder(base_from_decoder),
    .base_addr_high(base_addr_high), .broadcast_chain_addr(broadcast_chain_addr),
    .slot_position_code(slot_position_code), .blt_rd(blt_rd), .blt_end(blt_end),
    .blt_wide(1'b1), .buf_word(buf_word), .buf_valid(buf_valid), .buf_eob(buf_eob),
    .buf_last(buf_last), .buf_pop(buf_pop), .blt_data(blt_data), .blt_ack(blt_ack),
    .blt_berr(blt_berr), .module_reset(module_reset), .data_reset(data_reset));
  vmcr_buf_model u_buf (.mclk(mclk), .buf_pop(buf_pop), .buf_word(buf_word),
    .buf_valid(buf_valid), .buf_eob(buf_eob), .buf_last(buf_last));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [32:0] ex, input logic [32:0] got);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // a refused slot write leaves no note, so any answer to it is flagged by the monitor
  task automatic acc(input logic wr, input vmcr_word_t a, input vmcr_word_t d, input string nm);
    if (!(wr && a == `VMCR_OFF_SLOT)) rq.push_back('{nm, {17'h0_0000, d}, !wr});
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    cyc(1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cyc(1);
  endtask
  task automatic blt(input vmcr_data_t w, input logic berr);
    bq.push_back('{"blt", {berr, w}, 1'b1});
    blt_rd = 1'b1;
    cyc(1);
    blt_rd = 1'b0;
    cyc(1);
  endtask
  task automatic panel();
    dr = 1'b0;
    mr = 1'b0;
    lv[6] = 1'b1;
    for (int k = 0; k < 13; k++) begin
      cyc(1);
      dr = dr | (data_reset === 1'b1);
      mr = mr | (module_reset === 1'b1);
      if (k == 2) lv[6] = 1'b0;
    end
  endtask
  task automatic run(input vmcr_word_t c, input int nev);
    vmcr_data_t w [0:5];
    int n_rd;
    acc(1'b1, `VMCR_OFF_CTRL1, c, "w");
    for (int j = 0; j < 3 * nev; j++) begin
      w[j] = $urandom();
      u_buf.push(w[j], j % 3 == 2);
    end
    n_rd = c[2] ? 3 : 3 * nev;
    for (int j = 0; j < n_rd; j++) blt(w[j], c[5] && j == n_rd - 1);
    if (c[6]) blt(nv_word, c[5]);
    blt(nv_word, c[5]);
    blt_end = 1'b1;
    cyc(1);
    blt_end = 1'b0;
    cyc(1);
    $display("readout mode %h done", c);
  endtask
  always @(negedge mclk) begin
    if (reg_ack === 1'b1) begin
      if (rq.size() == 0) cmp("reg_ack", 33'h0, 33'h1);
      else begin
        n = rq.pop_front();
        if (n.chk) cmp(n.nm, n.ex, {17'h0_0000, reg_rdata});
      end
    end
    if (blt_ack === 1'b1 || blt_berr === 1'b1) begin
      if (bq.size() == 0) cmp("blt answer", 33'h0, 33'h1);
      else begin
        n = bq.pop_front();
        cmp(n.nm, n.ex, {blt_berr, blt_data});
      end
    end
    if (iack_ack === 1'b1) begin
      if (iq.size() == 0) cmp("iack answer", 33'h0, 33'h1);
      else begin
        n = iq.pop_front();
        cmp(n.nm, n.ex, {25'h0, iack_data});
      end
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    void'($urandom(42431));
    slot = 5'($urandom());
    rot = 8'($urandom());
    adhi = 8'($urandom());
    cyc(6);
    nrst = 1'b1;
    cyc(6);
    acc(1'b0, `VMCR_OFF_BCAST, 16'h00AA, "bcast");
    acc(1'b0, `VMCR_OFF_ILEV, 16'h0000, "ilev");
    acc(1'b0, `VMCR_OFF_IVEC, 16'h0000, "ivec");
    acc(1'b0, `VMCR_OFF_SET1, 16'h0000, "set1");
    acc(1'b0, `VMCR_OFF_CTRL1, 16'h0000, "ctrl1");
    acc(1'b0, `VMCR_OFF_SLOT, {11'h0, slot}, "slot");
    acc(1'b0, 16'h1030, 16'h0000, "unmapped");
    cmp("base", {25'h0, rot}, {25'h0, base_addr_high});
    $display("reset values done");
    acc(1'b1, `VMCR_OFF_ADHI, {8'hFF, adhi}, "w");
    acc(1'b1, `VMCR_OFF_BCAST, 16'hFF3C, "w");
    acc(1'b1, `VMCR_OFF_SET1, 16'hFF18, "w");
    acc(1'b0, `VMCR_OFF_SET1, 16'h0018, "set1");
    acc(1'b0, `VMCR_OFF_ADHI, {8'h00, adhi}, "adhi");
    cmp("base", {24'h0, 1'b1, adhi}, {24'h0, base_from_decoder, base_addr_high});
    cmp("bcast", 33'h3C, {25'h0, broadcast_chain_addr});
    acc(1'b1, `VMCR_OFF_CLR1, 16'h0008, "w");
    acc(1'b0, `VMCR_OFF_SET1, 16'h0010, "set1");
    acc(1'b1, `VMCR_OFF_SLOT, {11'h0, ~slot}, "w");
    cyc(2);
    acc(1'b0, `VMCR_OFF_SLOT, {11'h0, slot}, "slot");
    $display("set clear slot done");
    acc(1'b1, `VMCR_OFF_CTRL1, 16'h0074, "w");
    acc(1'b0, `VMCR_OFF_CTRL1, 16'h0074, "ctrl1");
    acc(1'b1, `VMCR_OFF_SET1, 16'h0088, "w");
    cyc(8);
    cmp("hold", 33'h1, {32'h0, module_reset});
    acc(1'b1, `VMCR_OFF_CLR1, 16'h0080, "w");
    cyc(4);
    cmp("hold", 33'h0, {32'h0, module_reset});
    acc(1'b0, `VMCR_OFF_SET1, 16'h0010, "set1");
    acc(1'b0, `VMCR_OFF_CTRL1, 16'h0010, "ctrl1");
    acc(1'b0, `VMCR_OFF_SLOT, {11'h0, slot}, "slot");
    $display("soft reset done");
    acc(1'b1, `VMCR_OFF_SET1, 16'h0008, "w");
    panel();
    cmp("panel soft", 33'h1, {32'h0, mr});
    acc(1'b0, `VMCR_OFF_SET1, 16'h0010, "set1");
    acc(1'b1, `VMCR_OFF_CTRL1, 16'h0000, "w");
    panel();
    cmp("panel data", 33'h2, {31'h0, dr, mr});
    $display("panel reset done");
    acc(1'b1, `VMCR_OFF_ILEV, 16'hFFFB, "w");
    acc(1'b0, `VMCR_OFF_ILEV, 16'h0003, "ilev");
    for (int i = 0; i < 6; i++) begin
      lv[5:0] = 6'($urandom());
      trig = 5'($urandom_range(31, 1));
      cnt = i[0] ? trig : 5'($urandom());
      cyc(4);
      acc(1'b0, `VMCR_OFF_STAT1, {7'h0, cnt >= trig, 4'h0, lv[3], lv[2] | lv[4] | lv[5],
        lv[1], lv[0]}, "stat1");
      cmp("irq", {32'h0, cnt == trig}, {32'h0, irq_req});
    end
    lv[5:0] = 6'h00;
    acc(1'b1, `VMCR_OFF_ILEV, 16'h0000, "w");
    cyc(2);
    cmp("irq off", 33'h0, {32'h0, irq_req});
    $display("status interrupt done");
    acc(1'b1, `VMCR_OFF_IVEC, 16'hFF5A, "w");
    acc(1'b0, `VMCR_OFF_IVEC, 16'h005A, "ivec");
    iq.push_back('{"vector", 33'h5A, 1'b1});
    iack = 1'b1;
    cyc(1);
    iack = 1'b0;
    cyc(2);
    $display("vector done");
    run(16'h0044, 1);
    run(16'h0024, 1);
    acc(1'b0, `VMCR_OFF_SET1, 16'h0018, "bus_error_flag");
    acc(1'b1, `VMCR_OFF_CLR1, 16'h0008, "w");
    run(16'h0020, 2);
    run(16'h0000, 1);
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(6);
    acc(1'b0, `VMCR_OFF_BCAST, 16'h00AA, "bcast");
    acc(1'b0, `VMCR_OFF_SLOT, {11'h0, slot}, "slot");
    $display("hardware reset done");
    cyc(2);
    cmp("pending", 33'h0, 33'(rq.size() + bq.size() + iq.size()));
    summarize();
  end
endmodule
